/* File: src/dasr_regs.sv */
// Access-layer control and status registers of the program and debug port, on AHB-Lite.
//
// Operation
// - User-row key status bit reads 1 while that key is active, else 0.
// - Memory-program key bit reads 1 while active, self-clears when programming finishes.
// - Full-erase key bit reads 1 while active, self-clears when erase completes.
// - Writing 0x59 to reset request register asserts and holds system reset.
// - Writing any other value to reset request register releases the held reset.
// - Reset request reads bit 0 as held-reset state, other bits zero.
// - The system reset issued here never resets this port logic.
// - Clock select codes 0..3 give 32/16/8/4 MHz; code 3 after reset and enable.
// - Writing 1 to finalise bit starts user-row programming from RAM into flash.
// - Finalise bit accepts writes only while the user-row key is decoded.
// - Clock request bit 1 requests system clock in any sleep; 0 withdraws it.
// - Clock request sets when the port is enabled and clears when disabled.
// - System-reset-active bit reads 1 while system in reset, clears on read.
// - In-sleep bit reads 1 while system is idle or deeper sleep.
// - Memory-programming-allowed bit set by device; tool then resets system when done.
// - User-row-programming-allowed bit set by device; tool then sets finalise bit.
// - Lock bit reads 1 while locked, 0 after erase; state register resets to 0x01.
// - Checksum status is one-hot: 0 off, 1 busy, 2 good, 4 failed.
// - Port disable resets the port, drops clock request, clears config and keys.
//
// Local design decision: the AHB-Lite interface to the registers.
module dasr_regs (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic port_disable_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic user_row_key_decoded_in,
  input wire logic memory_program_key_decoded_in,
  input wire logic full_erase_key_decoded_in,
  input wire logic memory_program_done_in,
  input wire logic full_erase_done_in,
  input wire logic system_in_reset_in,
  input wire logic system_sleeping_in,
  input wire logic memory_program_allowed_in,
  input wire logic user_row_program_allowed_in,
  input wire logic device_locked_in,
  input wire logic [2:0] checksum_status_in,
  output logic system_reset_request_out,
  output logic [1:0] port_clock_select_out,
  output logic system_clock_request_out,
  output logic user_row_finalise_out
);
  // Slot of each unlock key in the key vectors below.
  localparam int KEY_COUNT = 3;
  localparam int KEY_ERASE = 0;
  localparam int KEY_MEM_PROG = 1;
  localparam int KEY_USER_ROW = 2;

  logic wr_pend_q;
  logic [dasr_pkg::ADDR_W-1:0] wr_addr_q;
  logic [7:0] rd_data_d;
  logic rd_take;
  logic wr_take;
  logic [dasr_pkg::ADDR_W-1:0] rd_addr;
  logic [KEY_COUNT-1:0] key_set;
  logic [KEY_COUNT-1:0] key_clear;
  logic [KEY_COUNT-1:0] key_q;
  logic reset_hold_q;
  logic [1:0] clock_select_q;
  logic clock_request_q;
  logic finalise_q;
  logic disable_q;
  logic reset_seen_q;
  logic [7:0] wdata;
  logic hit_reset_request;
  logic hit_clock_divider;
  logic hit_system_control;
  logic read_state;
  logic sleeping_q;
  logic mem_allowed_q;
  logic row_allowed_q;
  logic locked_q;
  logic [2:0] checksum_q;
  logic [7:0] key_word;
  logic [7:0] reset_word;
  logic [7:0] divider_word;
  logic [7:0] control_word;
  logic [7:0] state_word;
  logic [7:0] checksum_word;

  // Maps a register index to its word address bits.
  function automatic logic [dasr_pkg::ADDR_W-1:0] word_of(input logic [7:0] idx);
    word_of = idx[dasr_pkg::ADDR_W-1:0];
  endfunction

  // A transfer is taken only for a selected, ready, non-sequential word access.
  function automatic logic take(input logic sel, input logic rdy, input logic [1:0] trans,
                                input logic [2:0] size);
    take = sel && rdy && (trans == dasr_pkg::HTRANS_NONSEQ) && (size == dasr_pkg::HSIZE_WORD);
  endfunction

  // A pending data phase writes the register whose index matches its address.
  function automatic logic wr_hit(input logic [7:0] idx, input logic pend,
                                  input logic [dasr_pkg::ADDR_W-1:0] a);
    wr_hit = pend && (a == word_of(idx));
  endfunction

  // Only the low byte of a word carries register data; upper bytes are ignored.
  assign wdata = hwdata_in[7:0];
  assign rd_take = take(hsel_in, hready_in, htrans_in, hsize_in) && !hwrite_in;
  assign wr_take = take(hsel_in, hready_in, htrans_in, hsize_in) && hwrite_in;
  assign rd_addr = haddr_in[dasr_pkg::ADDR_W+1:2];
  assign read_state = rd_take && (rd_addr == word_of(dasr_pkg::SYSTEM_STATE_IDX));
  assign hit_reset_request = wr_hit(dasr_pkg::SYSTEM_RESET_REQUEST_IDX, wr_pend_q, wr_addr_q);
  assign hit_clock_divider = wr_hit(dasr_pkg::PORT_CLOCK_DIVIDER_IDX, wr_pend_q, wr_addr_q);
  assign hit_system_control = wr_hit(dasr_pkg::SYSTEM_CONTROL_IDX, wr_pend_q, wr_addr_q);

  // Every access completes with zero wait states, so hreadyout stays high.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hreadyout_out <= 1'b1;
    end else begin
      hreadyout_out <= 1'b1;
    end
  end

  // Every access is legal, so the response is always OKAY.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hresp_out <= 1'b0;
    end else begin
      hresp_out <= 1'b0;
    end
  end

  // The address phase is held over into the data phase, where hwdata stands.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= wr_take;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_addr_q <= '0;
    end else begin
      wr_addr_q <= rd_addr;
    end
  end

  // Decode and completion inputs of each key, in slot order.
  assign key_set[KEY_ERASE] = full_erase_key_decoded_in;
  assign key_set[KEY_MEM_PROG] = memory_program_key_decoded_in;
  assign key_set[KEY_USER_ROW] = user_row_key_decoded_in;
  assign key_clear[KEY_ERASE] = full_erase_done_in;
  assign key_clear[KEY_MEM_PROG] = memory_program_done_in;
  // The user-row key has no completion event; it simply follows the decoder.
  assign key_clear[KEY_USER_ROW] = !user_row_key_decoded_in;

  // A newly decoded key wins over a completion in the same cycle.
  for (genvar k = 0; k < KEY_COUNT; k++) begin : g_key
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        key_q[k] <= 1'b0;
      end else if (port_disable_in) begin
        key_q[k] <= 1'b0;
      end else if (key_set[k]) begin
        key_q[k] <= 1'b1;
      end else if (key_clear[k]) begin
        key_q[k] <= 1'b0;
      end
    end
  end

  // The held reset goes to the system, its readback and reset-seen; it never resets this logic.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reset_hold_q <= 1'b0;
    end else if (port_disable_in) begin
      reset_hold_q <= 1'b0;
    end else if (hit_reset_request) begin
      reset_hold_q <= (wdata == dasr_pkg::RESET_SIGNATURE);
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      clock_select_q <= dasr_pkg::CLOCK_SELECT_RESET;
    end else if (port_disable_in) begin
      clock_select_q <= dasr_pkg::CLOCK_SELECT_RESET;
    end else if (hit_clock_divider) begin
      clock_select_q <= wdata[1:0];
    end
  end

  // The previous disable level marks the cycle in which the port comes back up.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      disable_q <= 1'b0;
    end else begin
      disable_q <= port_disable_in;
    end
  end

  // The port counts as enabled when reset ends, so the request starts raised.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      clock_request_q <= 1'b1;
    end else if (port_disable_in) begin
      clock_request_q <= 1'b0;
    end else if (disable_q) begin
      clock_request_q <= 1'b1;
    end else if (hit_system_control) begin
      clock_request_q <= wdata[dasr_pkg::CTRL_SYSTEM_CLOCK_REQUEST_BIT];
    end
  end

  // Finalise is a one-cycle start strobe, refused while the user-row key is absent.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      finalise_q <= 1'b0;
    end else if (port_disable_in) begin
      finalise_q <= 1'b0;
    end else begin
      finalise_q <= hit_system_control && wdata[dasr_pkg::CTRL_FINALISE_BIT] &&
                    key_q[KEY_USER_ROW];
    end
  end

  // Reset-seen is sticky; a read clears it but a reset still present wins.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      reset_seen_q <= 1'b0;
    end else if (system_in_reset_in || reset_hold_q) begin
      reset_seen_q <= 1'b1;
    end else if (read_state) begin
      reset_seen_q <= 1'b0;
    end
  end

  // Status inputs except system_in_reset_in are captured so a read sees one snapshot, at one cycle of lag.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sleeping_q <= 1'b0;
    end else begin
      sleeping_q <= system_sleeping_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem_allowed_q <= 1'b0;
    end else begin
      mem_allowed_q <= memory_program_allowed_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      row_allowed_q <= 1'b0;
    end else begin
      row_allowed_q <= user_row_program_allowed_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      locked_q <= dasr_pkg::SYSTEM_STATE_RESET[dasr_pkg::STATE_LOCK_BIT];
    end else begin
      locked_q <= device_locked_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      checksum_q <= dasr_pkg::CHECKSUM_OFF;
    end else begin
      checksum_q <= checksum_status_in;
    end
  end

  // Each register's read value is built apart, so the select below stays flat.
  always_comb begin
    key_word = 8'h00;
    key_word[dasr_pkg::KEY_USER_ROW_BIT] = key_q[KEY_USER_ROW];
    key_word[dasr_pkg::KEY_MEM_PROG_BIT] = key_q[KEY_MEM_PROG];
    key_word[dasr_pkg::KEY_ERASE_BIT] = key_q[KEY_ERASE];
  end

  always_comb begin
    reset_word = 8'h00;
    reset_word[0] = reset_hold_q;
  end

  always_comb begin
    divider_word = 8'h00;
    divider_word[1:0] = clock_select_q;
  end

  always_comb begin
    control_word = 8'h00;
    control_word[dasr_pkg::CTRL_SYSTEM_CLOCK_REQUEST_BIT] = clock_request_q;
  end

  always_comb begin
    state_word = 8'h00;
    state_word[dasr_pkg::STATE_RESET_BIT] = reset_seen_q || system_in_reset_in;
    state_word[dasr_pkg::STATE_SLEEP_BIT] = sleeping_q;
    state_word[dasr_pkg::STATE_MEM_PROG_BIT] = mem_allowed_q;
    state_word[dasr_pkg::STATE_USER_ROW_BIT] = row_allowed_q;
    state_word[dasr_pkg::STATE_LOCK_BIT] = locked_q;
  end

  always_comb begin
    checksum_word = 8'h00;
    checksum_word[2:0] = checksum_q;
  end

  always_comb begin
    rd_data_d = 8'h00;
    if (rd_addr == word_of(dasr_pkg::UNLOCK_KEY_STATE_IDX)) begin
      rd_data_d = key_word;
    end else if (rd_addr == word_of(dasr_pkg::SYSTEM_RESET_REQUEST_IDX)) begin
      rd_data_d = reset_word;
    end else if (rd_addr == word_of(dasr_pkg::PORT_CLOCK_DIVIDER_IDX)) begin
      rd_data_d = divider_word;
    end else if (rd_addr == word_of(dasr_pkg::SYSTEM_CONTROL_IDX)) begin
      rd_data_d = control_word;
    end else if (rd_addr == word_of(dasr_pkg::SYSTEM_STATE_IDX)) begin
      rd_data_d = state_word;
    end else if (rd_addr == word_of(dasr_pkg::CHECKSUM_STATE_IDX)) begin
      rd_data_d = checksum_word;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata_out <= {24'h00_0000, rd_data_d};
    end
  end

  // Outputs all come from flip-flops.
  assign system_reset_request_out = reset_hold_q;
  assign port_clock_select_out = clock_select_q;
  assign system_clock_request_out = clock_request_q;
  assign user_row_finalise_out = finalise_q;
endmodule // dasr_regs

/* File: src/dasr_pkg.sv */
// Package of offsets, field positions, reset values and codes for the access-layer registers.
package dasr_pkg;
  localparam logic [7:0] SYSTEM_RESET_REQUEST_IDX = 8'h08;
  localparam logic [7:0] PORT_CLOCK_DIVIDER_IDX = 8'h09;
  localparam logic [7:0] SYSTEM_CONTROL_IDX = 8'h0a;
  localparam logic [7:0] SYSTEM_STATE_IDX = 8'h0b;
  localparam logic [7:0] CHECKSUM_STATE_IDX = 8'h0c;
  localparam logic [7:0] UNLOCK_KEY_STATE_IDX = 8'h07;
  localparam int ADDR_W = 6;
  localparam logic [7:0] RESET_SIGNATURE = 8'h59;
  localparam logic [1:0] CLOCK_SELECT_RESET = 2'h3;
  localparam logic [7:0] SYSTEM_STATE_RESET = 8'h01;
  localparam int KEY_USER_ROW_BIT = 5;
  localparam int KEY_MEM_PROG_BIT = 4;
  localparam int KEY_ERASE_BIT = 3;
  localparam int CTRL_FINALISE_BIT = 1;
  localparam int CTRL_SYSTEM_CLOCK_REQUEST_BIT = 0;
  localparam int STATE_RESET_BIT = 5;
  localparam int STATE_SLEEP_BIT = 4;
  localparam int STATE_MEM_PROG_BIT = 3;
  localparam int STATE_USER_ROW_BIT = 2;
  localparam int STATE_LOCK_BIT = 0;
  localparam logic [2:0] CHECKSUM_OFF = 3'h0;
  localparam logic [2:0] CHECKSUM_BUSY = 3'h1;
  localparam logic [2:0] CHECKSUM_OK = 3'h2;
  localparam logic [2:0] CHECKSUM_FAIL = 3'h4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

/* File: testbench/dasr_regs_assertions.sv */
// Checker of port relations for the access-layer register block.
module dasr_regs_assertions (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic port_disable_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic user_row_key_decoded_in,
  input wire logic system_reset_request_out,
  input wire logic [1:0] port_clock_select_out,
  input wire logic system_clock_request_out,
  input wire logic user_row_finalise_out
);
  logic wr_q;
  logic [7:0] adr_q;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  // The address phase is remembered so the data phase can be tied to its register.
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_q <= 1'b0;
      adr_q <= 8'h00;
    end else begin
      wr_q <= hsel_in && htrans_in == dasr_pkg::HTRANS_NONSEQ && hwrite_in && hready_in;
      adr_q <= haddr_in[7:0];
    end
  end
  property p_sig; wr_q && adr_q == 8'h20 && hwdata_in[7:0] == 8'h59 |=> system_reset_request_out;
  endproperty
  a_sig: assert property (p_sig) else $error("reset request not raised");
  property p_clr; wr_q && adr_q == 8'h20 && hwdata_in[7:0] != 8'h59 |=> !system_reset_request_out;
  endproperty
  a_clr: assert property (p_clr) else $error("reset request not released");
  property p_sel; wr_q && adr_q == 8'h24 |=> port_clock_select_out == $past(hwdata_in[1:0]);
  endproperty
  a_sel: assert property (p_sel) else $error("clock select not written");
  property p_req; wr_q && adr_q == 8'h28 && !port_disable_in
    |=> system_clock_request_out == $past(hwdata_in[0]); endproperty
  a_req: assert property (p_req) else $error("clock request not written");
  property p_fin; $rose(user_row_finalise_out) |-> $past(user_row_key_decoded_in); endproperty
  a_fin: assert property (p_fin) else $error("finalise without key");
  property p_dis; port_disable_in |=> !system_clock_request_out && port_clock_select_out == 2'h3;
  endproperty
  a_dis: assert property (p_dis) else $error("disable did not clear port");
  property p_hold; system_reset_request_out && !port_disable_in && !(wr_q && adr_q == 8'h20)
    |=> system_reset_request_out || port_disable_in; endproperty
  a_hold: assert property (p_hold) else $error("held reset dropped");
  property p_en; $fell(port_disable_in) |-> ##[0:2] system_clock_request_out; endproperty
  a_en: assert property (p_en) else $error("clock request not set on enable");
endmodule // dasr_regs_assertions
bind dasr_regs dasr_regs_assertions chk (.*);

/* File: testbench/dasr_tool_model.sv */
// Model of the external tool, mastering the register bus.
module dasr_tool_model (
  input wire logic core_clk_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_in,
  output logic hsel_out,
  output logic [31:0] haddr_out,
  output logic [1:0] htrans_out,
  output logic hwrite_out,
  output logic [2:0] hsize_out,
  output logic [31:0] hwdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {hsel_out, haddr_out, htrans_out, hwrite_out, hsize_out, hwdata_out} = '0;
  // Offsets are register indices, so the byte address is four times the index.
  task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge core_clk_in);
    hsel_out <= 1'b1;
    haddr_out <= {22'h0, i, 2'h0};
    htrans_out <= dasr_pkg::HTRANS_NONSEQ;
    hwrite_out <= w;
    hsize_out <= dasr_pkg::HSIZE_WORD;
    do @(posedge core_clk_in); while (hready_in !== 1'b1);
    hsel_out <= 1'b0;
    htrans_out <= 2'h0;
    hwdata_out <= d;
    do @(posedge core_clk_in); while (hready_in !== 1'b1);
    r = hrdata_in;
    // Released write data shows the inverse so a stale value cannot pass.
    hwdata_out <= ~d;
  endtask
endmodule // dasr_tool_model

/* File: testbench/debug_access_sys_regs_tb.sv */
// Self-checking bench of the access-layer register block.
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module debug_access_sys_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 0, reset_n_in = 0, port_disable_in = 0, hsel_in, hwrite_in, hresp_out;
  logic [31:0] haddr_in, hwdata_in, hrdata_out;
  logic [1:0] htrans_in, port_clock_select_out;
  logic [2:0] hsize_in, checksum_status_in = 0;
  logic hreadyout_out, system_reset_request_out, system_clock_request_out, user_row_finalise_out;
  logic user_row_key_decoded_in = 0, memory_program_key_decoded_in = 0;
  logic full_erase_key_decoded_in = 0, memory_program_done_in = 0, full_erase_done_in = 0;
  logic system_in_reset_in = 0, system_sleeping_in = 0, memory_program_allowed_in = 0;
  logic user_row_program_allowed_in = 0, device_locked_in = 1;
  wire hready_in = hreadyout_out;
  int mismatches = 0, cmp_count = 0;
  always #20 core_clk_in = ~core_clk_in;
  dasr_regs dasr_regs_inst (.*);
  dasr_tool_model dasr_tool_model_inst (.core_clk_in, .hready_in(hreadyout_out),
    .hrdata_in(hrdata_out), .hsel_out(hsel_in), .haddr_out(haddr_in), .htrans_out(htrans_in),
    .hwrite_out(hwrite_in), .hsize_out(hsize_in), .hwdata_out(hwdata_in));
  task automatic wr(input logic [7:0] i, input logic [31:0] d);
    logic [31:0] r;
    dasr_tool_model_inst.xfer(1'b1, i, d, r);
    #1;
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e, input string n);
    logic [31:0] r;
    dasr_tool_model_inst.xfer(1'b0, i, 32'h0, r);
    `CHK(n, e, r)
  endtask
  task automatic t_reset;
    rd(8'h08, 32'h0, "reset_request");
    rd(8'h09, 32'h3, "divider");
    rd(8'h0b, 32'h1, "state");
    rd(8'h0c, 32'h0, "checksum");
    rd(8'h0f, 32'h0, "unmapped");
    `CHK("clock_request", 1'b1, system_clock_request_out)
    $display("test reset values ended");
  endtask
  task automatic t_reset_req;
    wr(8'h09, 32'h1);
    wr(8'h08, 32'h59);
    `CHK("reset_out", 1'b1, system_reset_request_out)
    rd(8'h08, 32'h1, "reset_request");
    rd(8'h09, 32'h1, "divider");
    wr(8'h08, 32'h5b);
    `CHK("reset_out", 1'b0, system_reset_request_out)
    rd(8'h08, 32'h0, "reset_request");
    $display("test reset request ended");
  endtask
  task automatic t_clock_select;
    for (int c = 0; c < 4; c++) begin
      wr(8'h09, c);
      `CHK("select", c[1:0], port_clock_select_out)
    end
    wr(8'h09, 32'hfc);
    rd(8'h09, 32'h0, "divider");
    wr(8'h09, 32'h3);
    $display("test clock select ended");
  endtask
  task automatic t_keys;
    for (int k = 0; k < 3; k++) begin
      @(posedge core_clk_in);
      {user_row_key_decoded_in, memory_program_key_decoded_in, full_erase_key_decoded_in} <=
        3'h4 >> k;
      memory_program_done_in <= (k == 2);
      rd(8'h07, 32'h20 >> k, "keys");
    end
    $display("test key status ended");
  endtask
  task automatic t_control;
    @(posedge core_clk_in);
    full_erase_key_decoded_in <= 1'b0;
    full_erase_done_in <= 1'b1;
    wr(8'h0a, 32'h2);
    `CHK("finalise", 1'b0, user_row_finalise_out)
    rd(8'h07, 32'h0, "keys");
    @(posedge core_clk_in);
    user_row_key_decoded_in <= 1'b1;
    wr(8'h0a, 32'h3);
    `CHK("finalise", 1'b1, user_row_finalise_out)
    wr(8'h0a, 32'h0);
    `CHK("clock_request", 1'b0, system_clock_request_out)
    wr(8'h0a, 32'h1);
    `CHK("clock_request", 1'b1, system_clock_request_out)
    $display("test system control ended");
  endtask
  task automatic t_status;
    logic [2:0] codes[4] = '{3'h0, 3'h1, 3'h2, 3'h4};
    @(posedge core_clk_in);
    {system_in_reset_in, system_sleeping_in, memory_program_allowed_in} <= 3'h7;
    {user_row_program_allowed_in, device_locked_in} <= 2'h2;
    @(posedge core_clk_in);
    system_in_reset_in <= 1'b0;
    rd(8'h0b, 32'h3c, "state");
    rd(8'h0b, 32'h1c, "state");
    foreach (codes[j]) begin
      @(posedge core_clk_in);
      checksum_status_in <= codes[j];
      rd(8'h0c, {29'h0, codes[j]}, "checksum");
    end
    $display("test system status ended");
  endtask
  task automatic t_disable;
    wr(8'h09, 32'h0);
    wr(8'h08, 32'h59);
    @(posedge core_clk_in);
    port_disable_in <= 1'b1;
    @(posedge core_clk_in);
    #1;
    `CHK("disabled", 4'h3, {system_reset_request_out, system_clock_request_out,
      port_clock_select_out})
    @(posedge core_clk_in);
    port_disable_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    `CHK("clock_request", 1'b1, system_clock_request_out)
    $display("test port disable ended");
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // The whole sequence needs about 125 cycles, so this limit only cuts a hang.
  initial begin
    repeat (5000) @(posedge core_clk_in);
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_reset_req();
    t_clock_select();
    t_keys();
    t_control();
    t_status();
    t_disable();
    wrap_up();
  end
endmodule // debug_access_sys_regs_tb
